// [ars_exec.sv]
`timescale 1ns/100ps
// Summary of operation
// RULE1: read opcodes move one to 256 sectors, count from transfer_count
// RULE2: a count of zero means 256 sectors for read and verify
// RULE3: start address is high, mid, low bytes as LBA 23-0
// RULE4: per sector: busy, fill buffer, DRQ, drop busy, interrupt
// RULE5: host reads all 512 bytes after each data-ready interrupt
// RULE6: after a good read the address shows the last sector read
// RULE7: read error stops there, address shows it, flawed data stays buffered
// RULE8: verify acts like read without DRQ and without data to host
// RULE9: verify sets busy on accept, clears it and interrupts when done
// RULE10: after a good verify the address shows the last sector verified
// RULE11: verify error stops there; count shows sectors not yet verified
// RULE12: any opcode 1x is recalibrate and completes doing nothing
// RULE13: request-sense puts previous extended error code in error register
// RULE14: codes 00, 01, 09, 20, 21, 2F for the general cases
// RULE15: codes 11, 18, 10/14, 1F, 03 for media and transfer faults
// RULE16: codes 35/36, 22 and the self-test, format, spare codes
// RULE17: disable-password takes one sector of data from the host
// RULE18: lock clears only when the selected stored password matches
// RULE19: disabling lock leaves the master password untouched
// RULE20: word 0 bit 0 picks user or master; words 1-16 hold password
// RULE21: a password mismatch aborts the command
// RULE22: host writes drive-head with bits 7,5 set, LBA bit, address 27-24
// RULE23: interrupt holds until status read; commands ignored while busy

// ****************************************************************
// buffer stage between media and sector buffer
// ****************************************************************
module ars_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;
   assign out_data_o = mem_reg[rd_ptr_reg];

   // occupancy; full and empty kept as flops so ready/valid are glitch free
   always_comb begin
      count_next = count_reg;
      if (push && !pop) count_next = count_reg + 1'b1;
      if (pop && !push) count_next = count_reg - 1'b1;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         count_reg   <= '0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg   <= count_next;
         in_ready_o  <= (count_next != (AW+1)'(DEPTH));
         out_valid_o <= (count_next != '0);
      end
   end

   // storage has no reset; empty flag guards stale words
   always_ff @(posedge clk_i) begin
      if (push) mem_reg[wr_ptr_reg] <= in_data_i;
   end
endmodule

// ****************************************************************
// command execution
// ****************************************************************
module ars_exec (
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic [2:0]    addr_i,
   input  wire logic          rd_i,
   input  wire logic          wr_i,
   input  wire logic [15:0]   wdata_i,
   output logic [15:0]        rdata_o,
   output logic               irq_o,
   output logic               media_req_o,
   output logic               media_vfy_o,
   output logic [27:0]        media_lba_o,
   input  wire logic          media_valid_i,
   input  wire logic [15:0]   media_data_i,
   output logic               media_ready_o,
   input  wire logic          media_done_i,
   input  wire logic          media_err_i,
   input  wire logic [7:0]    media_code_i,
   input  wire logic [255:0]  user_pw_i,
   input  wire logic [255:0]  master_pw_i,
   input  wire logic          lock_set_i,
   output logic               locked_o
);
   import ars_pkg::*;

   ars_state_type state_reg;
   logic [7:0]  count_reg, low_reg, mid_reg, high_reg, dh_reg, feat_reg;
   logic [7:0]  error_reg, ext_code_reg, media_code_reg;
   logic        busy_reg, drq_reg, errb_reg;
   logic        done_reg, filled_reg, media_err_reg, pw_id_reg, pw_bad_reg;
   logic [7:0]  wptr_reg, rptr_reg;
   logic [15:0] buf_reg [ARS_SECT_WORDS];
   logic [15:0] fifo_data;
   logic        fifo_valid, fifo_ready;
   logic        cmd_wr, status_rd, host_rd_data, host_wr_data;
   logic        sect_end, last_sect, fetch_done, buf_push;
   logic [27:0] lba_next;
   logic [15:0] pw_word;

   assign media_lba_o  = {dh_reg[3:0], high_reg, mid_reg, low_reg}; // RULE3
   assign lba_next     = media_lba_o + 28'h0000001;
   assign cmd_wr       = wr_i && addr_i == ARS_OFF_CMD && !busy_reg && !drq_reg; // RULE23
   assign status_rd    = rd_i && addr_i == ARS_OFF_CMD;
   assign host_rd_data = rd_i && addr_i == ARS_OFF_DATA && state_reg == ARS_XFER;
   assign host_wr_data = wr_i && addr_i == ARS_OFF_DATA && state_reg == ARS_PWIN;
   assign sect_end     = host_rd_data && rptr_reg == ARS_LAST_WORD; // RULE5
   assign last_sect    = count_reg == 8'h01; // zero counts as 256 via wrap
   assign fetch_done   = state_reg == ARS_FETCH && done_reg && (media_vfy_o || filled_reg);
   assign fifo_ready   = state_reg == ARS_FETCH && !media_vfy_o && !filled_reg;
   assign buf_push     = fifo_valid && fifo_ready;
   // word k of the password sector holds password bits 16(k-1) and up
   assign pw_word = pw_id_reg ? master_pw_i[16*(wptr_reg - ARS_PW_FIRST) +: 16]
                              : user_pw_i[16*(wptr_reg - ARS_PW_FIRST) +: 16]; // RULE20

   // media words pass a small queue; its ready stalls the media source
   ars_fifo #(
      .WIDTH (16),
      .DEPTH (ARS_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (media_valid_i),
      .in_ready_o  (media_ready_o),
      .in_data_i   (media_data_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_ready),
      .out_data_o  (fifo_data)
   );

   // sector buffer; left untouched after a fault so bad data can be read
   always_ff @(posedge clk_i) begin
      if (buf_push) buf_reg[wptr_reg] <= fifo_data; // RULE7
   end

   // ****************************************************************
   // sequencer and task-file registers
   // ****************************************************************
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg      <= ARS_IDLE;
         count_reg      <= 8'h01;
         low_reg        <= 8'h01;
         mid_reg        <= 8'h00;
         high_reg       <= 8'h00;
         dh_reg         <= ARS_DH_RST;
         feat_reg       <= 8'h00;
         error_reg      <= 8'h00;
         ext_code_reg   <= ARS_EX_NONE;
         media_code_reg <= ARS_EX_NONE;
         busy_reg       <= 1'b0;
         drq_reg        <= 1'b0;
         errb_reg       <= 1'b0;
         done_reg       <= 1'b0;
         filled_reg     <= 1'b0;
         media_err_reg  <= 1'b0;
         media_req_o    <= 1'b0;
         media_vfy_o    <= 1'b0;
         pw_id_reg      <= 1'b0;
         pw_bad_reg     <= 1'b0;
         wptr_reg       <= 8'h00;
         rptr_reg       <= 8'h00;
      end else begin
         // host register writes only while the device is idle
         if (wr_i && !busy_reg && !drq_reg) begin // RULE23
            unique case (addr_i)
               ARS_OFF_FEAT: feat_reg  <= wdata_i[7:0];
               ARS_OFF_CNT:  count_reg <= wdata_i[7:0];
               ARS_OFF_LOW:  low_reg   <= wdata_i[7:0];
               ARS_OFF_MID:  mid_reg   <= wdata_i[7:0];
               ARS_OFF_HIGH: high_reg  <= wdata_i[7:0];
               ARS_OFF_DH:   dh_reg    <= wdata_i[7:0]; // RULE22
               default: ;
            endcase
         end
         if (buf_push) begin
            wptr_reg <= wptr_reg + 8'h01;
            if (wptr_reg == ARS_LAST_WORD) filled_reg <= 1'b1;
         end
         if (media_done_i && media_req_o) begin
            media_req_o    <= 1'b0;
            done_reg       <= 1'b1;
            media_err_reg  <= media_err_i;
            media_code_reg <= media_code_i; // RULE15 RULE16
         end
         unique case (state_reg)
            ARS_IDLE: begin
               if (cmd_wr) begin
                  errb_reg   <= 1'b0;
                  error_reg  <= 8'h00;
                  done_reg   <= 1'b0;
                  filled_reg <= 1'b0;
                  wptr_reg   <= 8'h00;
                  rptr_reg   <= 8'h00;
                  if (wdata_i[7:0] == ARS_OP_READ0 || wdata_i[7:0] == ARS_OP_READ1 ||
                      wdata_i[7:0] == ARS_OP_VFY0 || wdata_i[7:0] == ARS_OP_VFY1) begin
                     busy_reg    <= 1'b1; // RULE4 RULE9
                     media_req_o <= 1'b1; // RULE1
                     media_vfy_o <= wdata_i[6]; // RULE8
                     state_reg   <= ARS_FETCH;
                  end else if (wdata_i[7:0] == ARS_OP_DISPW) begin
                     drq_reg    <= 1'b1; // RULE17
                     pw_bad_reg <= 1'b0;
                     state_reg  <= ARS_PWIN;
                  end else if (wdata_i[7:4] == ARS_OP_RECAL) begin
                     ext_code_reg <= ARS_EX_NONE; // RULE12
                  end else if (wdata_i[7:0] == ARS_OP_SENSE) begin
                     error_reg <= ext_code_reg; // RULE13
                  end else begin
                     errb_reg     <= 1'b1;
                     error_reg    <= ARS_ER_ABRT;
                     ext_code_reg <= ARS_EX_INVCMD; // RULE14
                  end
               end
            end
            ARS_FETCH: begin
               if (fetch_done) begin
                  done_reg     <= 1'b0;
                  ext_code_reg <= media_err_reg ? media_code_reg : ARS_EX_NONE;
                  if (media_err_reg) begin
                     errb_reg  <= 1'b1;
                     error_reg <= ARS_ER_UNC;
                  end
                  if (!media_vfy_o) begin
                     // sector buffered: offer it to the host
                     busy_reg  <= 1'b0;
                     drq_reg   <= 1'b1; // RULE4
                     rptr_reg  <= 8'h00;
                     state_reg <= ARS_XFER;
                  end else if (media_err_reg || last_sect) begin
                     // error keeps count and address on the failing sector
                     busy_reg  <= 1'b0; // RULE9 RULE11
                     state_reg <= ARS_IDLE;
                     if (!media_err_reg) count_reg <= count_reg - 8'h01; // RULE10
                  end else begin
                     count_reg <= count_reg - 8'h01; // RULE2
                     {dh_reg[3:0], high_reg, mid_reg, low_reg} <= lba_next;
                     media_req_o <= 1'b1;
                  end
               end
            end
            ARS_XFER: begin
               if (host_rd_data) rptr_reg <= rptr_reg + 8'h01;
               if (sect_end) begin
                  drq_reg   <= 1'b0;
                  count_reg <= count_reg - 8'h01;
                  if (media_err_reg || last_sect) begin
                     state_reg <= ARS_IDLE; // RULE6 RULE7
                  end else begin
                     // next sector; no address step past the final one
                     {dh_reg[3:0], high_reg, mid_reg, low_reg} <= lba_next;
                     busy_reg    <= 1'b1; // RULE4
                     media_req_o <= 1'b1;
                     filled_reg  <= 1'b0;
                     wptr_reg    <= 8'h00;
                     state_reg   <= ARS_FETCH;
                  end
               end
            end
            ARS_PWIN: begin
               if (host_wr_data) begin
                  wptr_reg <= wptr_reg + 8'h01;
                  if (wptr_reg == 8'h00) pw_id_reg <= wdata_i[0]; // RULE20
                  if (wptr_reg >= ARS_PW_FIRST && wptr_reg <= ARS_PW_LAST &&
                      wdata_i != pw_word) pw_bad_reg <= 1'b1; // RULE18
                  if (wptr_reg == ARS_LAST_WORD) begin
                     drq_reg   <= 1'b0;
                     state_reg <= ARS_IDLE;
                     if (pw_bad_reg || (wptr_reg >= ARS_PW_FIRST && wptr_reg <= ARS_PW_LAST &&
                         wdata_i != pw_word)) begin
                        errb_reg     <= 1'b1; // RULE21
                        error_reg    <= ARS_ER_ABRT;
                        ext_code_reg <= ARS_EX_ABORT;
                     end else begin
                        ext_code_reg <= ARS_EX_NONE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // lock mode; master password inputs are only ever compared
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         locked_o <= 1'b0;
      end else if (lock_set_i) begin
         locked_o <= 1'b1;
      end else if (host_wr_data && wptr_reg == ARS_LAST_WORD && !pw_bad_reg) begin
         locked_o <= 1'b0; // RULE18 RULE19
      end
   end

   // interrupt: a completion in the status-read cycle wins over the clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else if ((fetch_done && (!media_vfy_o || media_err_reg || last_sect)) ||
                   (host_wr_data && wptr_reg == ARS_LAST_WORD) ||
                   (cmd_wr && state_reg == ARS_IDLE &&
                    !(wdata_i[7:0] == ARS_OP_READ0 || wdata_i[7:0] == ARS_OP_READ1 ||
                      wdata_i[7:0] == ARS_OP_VFY0 || wdata_i[7:0] == ARS_OP_VFY1 ||
                      wdata_i[7:0] == ARS_OP_DISPW))) begin
         irq_o <= 1'b1; // RULE4 RULE9
      end else if (status_rd) begin
         irq_o <= 1'b0; // RULE23
      end
   end

   // read data; a data read outside a transfer returns zero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         unique case (addr_i)
            ARS_OFF_DATA: rdata_o <= host_rd_data ? buf_reg[rptr_reg] : 16'h0000;
            ARS_OFF_FEAT: rdata_o <= {8'h00, error_reg};
            ARS_OFF_CNT:  rdata_o <= {8'h00, count_reg};
            ARS_OFF_LOW:  rdata_o <= {8'h00, low_reg};
            ARS_OFF_MID:  rdata_o <= {8'h00, mid_reg};
            ARS_OFF_HIGH: rdata_o <= {8'h00, high_reg};
            ARS_OFF_DH:   rdata_o <= {8'h00, dh_reg};
            ARS_OFF_CMD:  rdata_o <= {8'h00, busy_reg, 1'b1, 1'b0, 1'b1,
                                      drq_reg, 2'b00, errb_reg};
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_sector_ready;
      fetch_done && !media_vfy_o;
   endsequence
   sequence s_next_sector;
      sect_end && !media_err_reg && !last_sect;
   endsequence

   a_drq_after_fill: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
      s_sector_ready |=> drq_reg && !busy_reg && irq_o)
      else $error("sector ready without drq, busy drop and interrupt");
   a_next_sector_busy: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
      s_next_sector |=> busy_reg && !drq_reg && media_req_o && state_reg == ARS_FETCH)
      else $error("next sector not fetched under busy");
   a_addr_step: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
      s_next_sector |=> media_lba_o == $past(media_lba_o) + 28'h0000001)
      else $error("address did not step by one sector");
   a_last_addr_hold: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
      sect_end && last_sect |=> $stable(media_lba_o) && state_reg == ARS_IDLE)
      else $error("address moved after final sector");
   a_verify_no_drq: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
      media_vfy_o && state_reg == ARS_FETCH |-> !drq_reg)
      else $error("drq raised during verify");
   a_verify_err_cnt: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
      fetch_done && media_vfy_o && media_err_reg |=> $stable(count_reg) && !busy_reg ##1 irq_o)
      else $error("verify error lost count or completion");
   a_irq_hold: assert property (@(posedge clk_i) disable iff (reset_i) // RULE23
      irq_o && !status_rd |=> irq_o)
      else $error("interrupt dropped without status read");
   a_busy_ignores: assert property (@(posedge clk_i) disable iff (reset_i) // RULE23
      (busy_reg || drq_reg) && wr_i && addr_i == ARS_OFF_MID && !fetch_done && !sect_end
      |=> $stable(mid_reg))
      else $error("register write taken while busy");
   a_sense_code: assert property (@(posedge clk_i) disable iff (reset_i) // RULE13
      cmd_wr && state_reg == ARS_IDLE && wdata_i[7:0] == ARS_OP_SENSE
      |=> error_reg == $past(ext_code_reg))
      else $error("sense did not return previous code");
   a_pw_mismatch: assert property (@(posedge clk_i) disable iff (reset_i) // RULE21
      host_wr_data && wptr_reg == ARS_LAST_WORD && pw_bad_reg
      |=> errb_reg && ext_code_reg == ARS_EX_ABORT && $stable(locked_o))
      else $error("bad password not aborted");
endmodule

// [ars_pkg.sv]
package ars_pkg;
   // task-file offsets (data port shares the block's 3-bit address)
   localparam logic [2:0] ARS_OFF_DATA = 3'h0;
   localparam logic [2:0] ARS_OFF_FEAT = 3'h1; // error on read
   localparam logic [2:0] ARS_OFF_CNT  = 3'h2;
   localparam logic [2:0] ARS_OFF_LOW  = 3'h3;
   localparam logic [2:0] ARS_OFF_MID  = 3'h4;
   localparam logic [2:0] ARS_OFF_HIGH = 3'h5;
   localparam logic [2:0] ARS_OFF_DH   = 3'h6;
   localparam logic [2:0] ARS_OFF_CMD  = 3'h7; // status on read
   // opcodes
   localparam logic [7:0] ARS_OP_READ0 = 8'h20;
   localparam logic [7:0] ARS_OP_READ1 = 8'h21;
   localparam logic [7:0] ARS_OP_VFY0  = 8'h40;
   localparam logic [7:0] ARS_OP_VFY1  = 8'h41;
   localparam logic [3:0] ARS_OP_RECAL = 4'h1;
   localparam logic [7:0] ARS_OP_SENSE = 8'h03;
   localparam logic [7:0] ARS_OP_DISPW = 8'hF6;
   // extended error codes
   localparam logic [7:0] ARS_EX_NONE    = 8'h00;
   localparam logic [7:0] ARS_EX_SELFOK  = 8'h01;
   localparam logic [7:0] ARS_EX_MISC    = 8'h09;
   localparam logic [7:0] ARS_EX_INVCMD  = 8'h20;
   localparam logic [7:0] ARS_EX_INVADR  = 8'h21;
   localparam logic [7:0] ARS_EX_ADROVF  = 8'h2F;
   localparam logic [7:0] ARS_EX_VOLT0   = 8'h35;
   localparam logic [7:0] ARS_EX_VOLT1   = 8'h36;
   localparam logic [7:0] ARS_EX_UNC     = 8'h11;
   localparam logic [7:0] ARS_EX_CORR    = 8'h18;
   localparam logic [7:0] ARS_EX_IDNF0   = 8'h10;
   localparam logic [7:0] ARS_EX_IDNF1   = 8'h14;
   localparam logic [7:0] ARS_EX_ABORT   = 8'h1F;
   localparam logic [7:0] ARS_EX_WRFAIL  = 8'h03;
   localparam logic [7:0] ARS_EX_PL1OFF  = 8'h22;
   localparam logic [7:0] ARS_EX_SELFBAD = 8'h05;
   localparam logic [7:0] ARS_EX_SPARE   = 8'h3A;
   localparam logic [7:0] ARS_EX_MEDIA   = 8'h0C;
   // error register bits
   localparam logic [7:0] ARS_ER_ABRT = 8'h04;
   localparam logic [7:0] ARS_ER_UNC  = 8'h40;
   // reset values and sector geometry
   localparam logic [7:0] ARS_DH_RST     = 8'hA0;
   localparam logic [7:0] ARS_LAST_WORD  = 8'hFF;
   localparam logic [7:0] ARS_PW_FIRST   = 8'h01;
   localparam logic [7:0] ARS_PW_LAST    = 8'h10;
   localparam int         ARS_SECT_WORDS = 256;
   localparam int         ARS_FIFO_DEPTH = 4;

   typedef enum logic [1:0] {ARS_IDLE, ARS_FETCH, ARS_XFER, ARS_PWIN} ars_state_type;
endpackage

// [ars_media_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// media side model: one sector of words per read request, none per verify request
// ****************************************************************
module ars_media_model (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        req_i,
   input  wire logic        vfy_i,
   input  wire logic [27:0] lba_i,
   input  wire logic        ready_i,
   input  wire logic        slow_i,
   input  wire logic [27:0] bad_lba_i,
   output logic             valid_o,
   output logic [15:0]      data_o,
   output logic             done_o,
   output logic             err_o,
   output logic [7:0]       code_o
);
   import ars_pkg::*;
   logic [8:0]  cnt_reg;
   logic [3:0]  wait_reg;
   logic        hold_reg;
   logic [27:0] lba_reg;
   logic        fin;
   // slow mode stalls 15 cycles before each read sector; verify moves no words and never stalls
   assign fin     = cnt_reg == 9'h100 || vfy_i;
   assign valid_o = req_i && !hold_reg && !fin && (!slow_i || &wait_reg);
   // idle bus shows inverted data so a stale word never matches
   assign data_o  = valid_o ? {lba_i[7:0], cnt_reg[7:0]} : ~{lba_i[7:0], cnt_reg[7:0]};
   assign err_o   = done_o && lba_i == bad_lba_i;
   assign code_o  = err_o ? ARS_EX_UNC : ~ARS_EX_UNC;
   // hold after done until the request drops or moves to a new sector
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_reg  <= 9'h000;
         wait_reg <= 4'h0;
         hold_reg <= 1'b0;
         lba_reg  <= 28'h0000000;
         done_o   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!req_i || (hold_reg && lba_i != lba_reg)) begin
            hold_reg <= 1'b0;
            wait_reg <= 4'h0;
         end else if (!hold_reg && fin) begin
            done_o   <= 1'b1;
            hold_reg <= 1'b1;
            lba_reg  <= lba_i;
            cnt_reg  <= 9'h000;
         end else if (!hold_reg) begin
            if (!(&wait_reg)) wait_reg <= wait_reg + 4'h1;
            if (valid_o && ready_i) cnt_reg <= cnt_reg + 9'h001;
         end
      end
   end
endmodule

// [tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %h want %h", $time, a, e); end end
// ****************************************************************
// host side bench
// ****************************************************************
module tb;
   import ars_pkg::*;
   logic         clk_i = 1'b0, reset_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0;
   logic         slow = 1'b1, lock_set = 1'b0, irq_o, locked;
   logic [2:0]   addr_i = 3'h0;
   logic [15:0]  wdata_i = 16'h0000, rdata_o, m_data;
   logic         m_req, m_vfy, m_valid, m_ready, m_done, m_err;
   logic [7:0]   m_code;
   logic [27:0]  m_lba, bad_lba = 28'hFFFFFFF;
   logic [255:0] user_pw = '0, master_pw = '0;
   logic [15:0]  rst_val [6] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h00A0};
   logic [7:0]   ops [4] = '{8'h10, 8'h17, 8'h1F, 8'h99};
   logic [15:0]  sts [4] = '{16'h0050, 16'h0050, 16'h0050, 16'h0051};
   logic [7:0]   codes [4] = '{8'h00, 8'h00, 8'h00, 8'h20};
   int           n_errors = 0;
   int           n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   ars_exec i_ars_exec (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i),
      .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .media_req_o(m_req),
      .media_vfy_o(m_vfy), .media_lba_o(m_lba), .media_valid_i(m_valid), .media_data_i(m_data),
      .media_ready_o(m_ready), .media_done_i(m_done), .media_err_i(m_err),
      .media_code_i(m_code), .user_pw_i(user_pw), .master_pw_i(master_pw),
      .lock_set_i(lock_set), .locked_o(locked));
   ars_media_model i_ars_media_model (.clk_i(clk_i), .reset_i(reset_i), .req_i(m_req),
      .vfy_i(m_vfy), .lba_i(m_lba), .ready_i(m_ready), .slow_i(slow), .bad_lba_i(bad_lba),
      .valid_o(m_valid), .data_o(m_data), .done_o(m_done), .err_o(m_err), .code_o(m_code));
   task automatic stop_test;
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one-cycle strobes driven at the falling edge
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(negedge clk_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge clk_i);
      wr_i = 1'b0;
   endtask
   task automatic chk_rd(input logic [2:0] a, input logic [15:0] e);
      @(negedge clk_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clk_i);
      rd_i = 1'b0;
      `CHK(rdata_o, e)
   endtask
   task automatic wirq;
      for (int i = 0; i < 20000 && irq_o !== 1'b1; i++) @(negedge clk_i);
      if (irq_o !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: no interrupt", $time);
         stop_test();
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      wr(ARS_OFF_CMD, {8'h00, op});
      wirq();
   endtask
   task automatic setp(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l,
                       input logic [7:0] c);
      wr(ARS_OFF_HIGH, {8'h00, h});
      wr(ARS_OFF_MID, {8'h00, m});
      wr(ARS_OFF_LOW, {8'h00, l});
      wr(ARS_OFF_CNT, {8'h00, c});
   endtask
   task automatic rd_sec(input logic [7:0] b);
      for (int i = 0; i < ARS_SECT_WORDS; i++) chk_rd(ARS_OFF_DATA, {b, i[7:0]});
   endtask
   task automatic sense(input logic [7:0] c);
      cmd(ARS_OP_SENSE);
      chk_rd(ARS_OFF_CMD, 16'h0050);
      chk_rd(ARS_OFF_FEAT, {8'h00, c});
   endtask
   // password sector: selector word, 16 password words, reserved zeros
   task automatic pw(input logic id, input logic [15:0] flip);
      wr(ARS_OFF_CMD, {8'h00, ARS_OP_DISPW});
      for (int k = 0; k < ARS_SECT_WORDS; k++)
         wr(ARS_OFF_DATA, k == 0 ? {15'h0000, id} : k <= 16 ? (16'hA500 + k[15:0]) ^ flip
            : 16'h0000);
      wirq();
   endtask
   initial begin
      for (int k = 1; k <= 16; k++) master_pw[16*(k-1) +: 16] = 16'hA500 + k[15:0];
      user_pw = ~master_pw;
      repeat (10) @(negedge clk_i);
      reset_i = 1'b0;
      foreach (rst_val[i]) chk_rd(3'(i + 1), rst_val[i]);
      chk_rd(ARS_OFF_CMD, 16'h0050);
      // two sectors with a slow media side
      wr(ARS_OFF_DH, 16'h00E0);
      setp(8'h12, 8'h34, 8'hFE, 8'h02);
      wr(ARS_OFF_CMD, {8'h00, ARS_OP_READ0});
      `CHK(m_lba, 28'h01234FE)
      wirq();
      chk_rd(ARS_OFF_CMD, 16'h0058);
      `CHK(irq_o, 1'b0)
      wr(ARS_OFF_MID, 16'h0055);
      rd_sec(8'hFE);
      wirq();
      chk_rd(ARS_OFF_CMD, 16'h0058);
      rd_sec(8'hFF);
      chk_rd(ARS_OFF_CMD, 16'h0050);
      chk_rd(ARS_OFF_LOW, 16'h00FF);
      chk_rd(ARS_OFF_MID, 16'h0034);
      // count zero verify covers 256 sectors
      slow = 1'b0;
      setp(8'h00, 8'h00, 8'h00, 8'h00);
      wr(ARS_OFF_CMD, {8'h00, ARS_OP_VFY0});
      chk_rd(ARS_OFF_CMD, 16'h00D0);
      wirq();
      chk_rd(ARS_OFF_CMD, 16'h0050);
      chk_rd(ARS_OFF_LOW, 16'h00FF);
      chk_rd(ARS_OFF_MID, 16'h0000);
      // verify stops at a bad second sector
      bad_lba = 28'h0000011;
      setp(8'h00, 8'h00, 8'h10, 8'h03);
      cmd(ARS_OP_VFY1);
      chk_rd(ARS_OFF_CMD, 16'h0051);
      chk_rd(ARS_OFF_LOW, 16'h0011);
      chk_rd(ARS_OFF_CNT, 16'h0002);
      sense(ARS_EX_UNC);
      // read error keeps the flawed sector readable
      bad_lba = 28'h0000020;
      setp(8'h00, 8'h00, 8'h20, 8'h01);
      cmd(ARS_OP_READ1);
      chk_rd(ARS_OFF_CMD, 16'h0059);
      rd_sec(8'h20);
      chk_rd(ARS_OFF_LOW, 16'h0020);
      bad_lba = 28'hFFFFFFF;
      foreach (ops[i]) begin
         cmd(ops[i]);
         chk_rd(ARS_OFF_CMD, sts[i]);
         sense(codes[i]);
      end
      // lock, wrong user password, then master and user matches
      for (int n = 0; n < 3; n++) begin
         @(negedge clk_i) lock_set = 1'b1;
         @(negedge clk_i) lock_set = 1'b0;
         if (n == 0) begin
            pw(1'b0, 16'h0000);
            chk_rd(ARS_OFF_FEAT, 16'h0004);
            `CHK(locked, 1'b1)
            sense(ARS_EX_ABORT);
         end else begin
            pw(n == 1, n == 1 ? 16'h0000 : 16'hFFFF);
            chk_rd(ARS_OFF_CMD, 16'h0050);
            `CHK(locked, 1'b0)
         end
      end
      stop_test();
   end
endmodule
